// file: dv/rsp_core_assertions.sv
`timescale 1ns/1ps
module rsp_core_assertions
  import rsp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  phase_out,
  input wire logic        device_reset,
  input wire logic        ctx_restore_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_phase_onehot: assert property ($onehot(phase_out))
    else $error("phase not one-hot");
  a_phase_wrap: assert property (phase_out[3] |=> phase_out[0])
    else $error("phase four not followed by phase one");
  a_phase_walk: assert property (
    phase_out[0] |=> phase_out[1] ##1 phase_out[2] ##1 phase_out[3])
    else $error("phase order broken");
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("access not answered at once");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
    else $error("unmapped access not refused");
  a_pointer_ok: assert property (psel && penable && paddr == 12'h000 |-> !pslverr)
    else $error("pointer access refused");
  a_reset_pulse: assert property (device_reset |=> !device_reset)
    else $error("device reset longer than one cycle");
  a_restore_pulse: assert property (ctx_restore_valid |=> !ctx_restore_valid)
    else $error("restore strobe longer than one cycle");
endmodule // rsp_core_assertions

bind rsp_core rsp_core_assertions chk_u (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .phase_out(phase_out), .device_reset(device_reset), .ctx_restore_valid(ctx_restore_valid));

// file: dv/rsp_core_model.sv
`timescale 1ns/1ps
module rsp_core_model
  import rsp_pkg::*;
(
  input  wire logic [3:0] phase_out,
  input  wire logic       mclk,
  output rsp_req_t        core_req,
  output rsp_ctx_t        core_ctx,
  output logic [15:0]     fetch_word,
  output logic [7:0]      table_byte,
  output logic            table_read
);
  initial begin
    core_req = '0;
    core_ctx = '0;
    fetch_word = 16'h0000;
    table_byte = 8'h00;
    table_read = 1'b0;
  end

  // Memory data moves every cycle so a latch that misses its phase shows up
  always @(posedge mclk) begin
    fetch_word <= fetch_word + 16'h1235;
    table_byte <= table_byte + 8'h3B;
    table_read <= ~table_read;
  end

  // Request held from phase one through the phase-four sample only
  task issue(input rsp_req_t r, input rsp_ctx_t c);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      if (phase_out[3]) break;
    end
    core_req <= r;
    core_ctx <= c;
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      if (phase_out[3]) break;
    end
    core_req <= '0;
  endtask
endmodule // rsp_core_model

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rsp_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, table_read, instr_valid, ctx_restore_valid, device_reset;
  rsp_req_t core_req;
  rsp_ctx_t core_ctx, ctx_restore, got_ctx;
  logic [15:0] fetch_word, instr_out;
  logic [7:0] table_byte;
  logic [20:0] pc_out, table_addr;
  logic [3:0] phase_out;
  int n_errors = 0, cmp_count = 0, n_rst = 0, n_ret = 0, n_flush = 0, c0;

  always #2.5 mclk = ~mclk;

  rsp_core dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .core_req(core_req), .core_ctx(core_ctx), .fetch_word(fetch_word),
    .table_byte(table_byte), .table_read(table_read), .pc_out(pc_out),
    .instr_out(instr_out), .instr_valid(instr_valid), .phase_out(phase_out),
    .ctx_restore(ctx_restore), .ctx_restore_valid(ctx_restore_valid),
    .table_addr(table_addr), .device_reset(device_reset));
  rsp_core_model core_u (.phase_out(phase_out), .mclk(mclk), .core_req(core_req),
    .core_ctx(core_ctx), .fetch_word(fetch_word), .table_byte(table_byte),
    .table_read(table_read));

  always @(posedge mclk) begin
    if (device_reset === 1'b1) n_rst <= n_rst + 1;
    if (ctx_restore_valid === 1'b1) n_ret <= n_ret + 1;
    if (ctx_restore_valid === 1'b1) got_ctx <= ctx_restore;
    if (instr_valid === 1'b0) n_flush <= n_flush + 1;
  end

  task test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  // Master holds the request until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_cnt(ref int c, input int c_old);
    for (int k = 0; k < 40 && c == c_old; k++) @(posedge mclk);
    if (c == c_old) begin
      n_errors++;
      test_done();
    end
  endtask

  task rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd_chk("pointer reset", ADDR_RETURN_STACK_POINTER_REG, 32'h0000_0000);
    rd_chk("config reset", ADDR_CONFIG, 32'h0000_0001);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    $display("test reset done");
    apb(1'b1, ADDR_CONFIG, 32'h0000_0000);
    for (int i = 0; i < 32; i++) core_u.issue(6'h20, '0);
    rd_chk("full hold", ADDR_RETURN_STACK_POINTER_REG, 32'h0000_009F);
    apb(1'b1, ADDR_RETURN_STACK_POINTER_REG, 32'h0000_0080);
    rd_chk("flag write one", ADDR_RETURN_STACK_POINTER_REG, 32'h0000_0080);
    apb(1'b1, ADDR_RETURN_STACK_POINTER_REG, 32'h0000_0005);
    rd_chk("flag clear", ADDR_RETURN_STACK_POINTER_REG, 32'h0000_0005);
    apb(1'b1, ADDR_TOP_OF_STACK_LOW, 32'h0000_005A);
    rd_chk("top low", ADDR_TOP_OF_STACK_LOW, 32'h0000_005A);
    core_u.issue(6'h20, '0);
    rd_chk("push ptr", ADDR_RETURN_STACK_POINTER_REG, 32'h0000_0006);
    core_u.issue(6'h10, '0);
    rd_chk("pop top", ADDR_TOP_OF_STACK_LOW, 32'h0000_005A);
    for (int i = 0; i < 6; i++) core_u.issue(6'h10, '0);
    rd_chk("underflow", ADDR_RETURN_STACK_POINTER_REG, 32'h0000_0040);
    chk("no reset", 32'h0000_0000, n_rst);
    $display("test stack done");
    apb(1'b1, ADDR_CONFIG, 32'h0000_0001);
    apb(1'b1, ADDR_RETURN_STACK_POINTER_REG, 32'h0000_001E);
    c0 = n_rst;
    core_u.issue(6'h20, '0);
    wait_cnt(n_rst, c0);
    rd_chk("full reset", ADDR_RETURN_STACK_POINTER_REG, 32'h0000_0080);
    $display("test overflow reset done");
    c0 = n_ret;
    core_u.issue(6'h02, 20'h1_2345);
    core_u.issue(6'h01, 20'h0_0000);
    wait_cnt(n_ret, c0);
    chk("fast call", 32'h0001_2345, {12'h000, got_ctx});
    c0 = n_ret;
    core_u.issue(6'h04, 20'hA_5C3E);
    core_u.issue(6'h04, 20'h6_7F1D);
    core_u.issue(6'h01, 20'h0_0000);
    wait_cnt(n_ret, c0);
    chk("nested irq", 32'h0006_7F1D, {12'h000, got_ctx});
    c0 = n_flush;
    core_u.issue(6'h08, '0);
    wait_cnt(n_flush, c0);
    $display("test context and flush done");
    chk("pc even", 32'h0000_0000, {31'h0, pc_out[0]});
    rd_chk("shadow hidden", ADDR_SHADOW, 32'h0000_0000);
    apb(1'b1, ADDR_TABLE_PTR, 32'h0000_1234);
    rd_chk("table ptr", ADDR_TABLE_PTR, 32'h0000_1234);
    chk("table addr", 32'h0000_1234, {11'h000, table_addr});
    $display("test table done");
    test_done();
  end

  initial begin
    #400000;
    n_errors++;
    test_done();
  end
endmodule // tb_top

// file: verilog/rsp_core.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module rsp_core
  import rsp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire rsp_req_t          core_req,
  input  wire rsp_ctx_t          core_ctx,
  input  wire logic [15:0]       fetch_word,
  input  wire logic [7:0]        table_byte,
  input  wire logic              table_read,
  output logic [20:0]            pc_out,
  output logic [15:0]            instr_out,
  output logic                   instr_valid,
  output logic [3:0]             phase_out,
  output rsp_ctx_t               ctx_restore,
  output logic                   ctx_restore_valid,
  output logic [20:0]            table_addr,
  output logic                   device_reset
);

  logic [20:0] stack_reg [1:SP_MAX];
  logic [4:0]  sp_reg;
  logic        full_reg;
  logic        under_reg;
  logic        cfg_reg;
  logic [20:0] pc_reg;
  logic [15:0] ir_reg;
  logic        flush_reg;
  logic        ivalid_reg;
  rsp_ctx_t    shadow_reg;
  rsp_ctx_t    restore_reg;
  logic        restore_v_reg;
  logic [20:0] table_pointer_reg;
  logic [7:0]  table_latch_reg;
  logic        devrst_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic [3:0]  phase;

  rsp_phase_gen u_phase (
    .mclk         (mclk),
    .rst          (rst),
    .phase_onehot (phase)
  );

  wire ph1 = phase[0];
  wire ph4 = phase[3];

  // APB decode: zero-wait, answer in the access cycle
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire hit_sp  = (paddr == ADDR_RETURN_STACK_POINTER_REG);
  wire hit_tu  = (paddr == ADDR_TOP_OF_STACK_UPPER);
  wire hit_th  = (paddr == ADDR_TOP_OF_STACK_HIGH);
  wire hit_tl  = (paddr == ADDR_TOP_OF_STACK_LOW);
  wire hit_cfg = (paddr == ADDR_CONFIG);
  wire hit_st  = (paddr == ADDR_STATUS);
  wire hit_sh  = (paddr == ADDR_SHADOW);
  wire hit_tp  = (paddr == ADDR_TABLE_PTR);
  wire hit_tlt = (paddr == ADDR_TABLE_LAT);
  wire mapped  = hit_sp | hit_tu | hit_th | hit_tl | hit_cfg | hit_st | hit_sh | hit_tp | hit_tlt;

  wire [20:0] top_of_stack = (sp_reg == SP_RESET) ? PC_RESET : stack_reg[sp_reg];

  // Requests act once per instruction cycle at phase four
  wire do_push = ph4 & core_req.push & ~flush_reg;
  wire do_pop  = ph4 & core_req.pop & ~flush_reg;
  wire at_full = (sp_reg == SP_MAX - 5'h01);
  wire is_full = (sp_reg == SP_MAX);
  wire empty   = (sp_reg == SP_RESET);

  wire push_ovf = do_push & at_full;
  wire pop_unf  = do_pop & empty;
  wire trip     = cfg_reg & (push_ovf | pop_unf);
  wire sw_sp    = wr & hit_sp;

  wire flag_full_set  = push_ovf | (do_push & is_full);
  wire flag_under_set = pop_unf;

  // Pointer, flags and stack entries
  always_ff @(posedge mclk) begin
    if (rst) begin
      sp_reg    <= SP_RESET;
      full_reg  <= 1'b0;
      under_reg <= 1'b0;
    end else begin
      if (trip) begin
        sp_reg <= SP_RESET;
      end else if (do_push && !is_full) begin
        sp_reg <= sp_reg + 5'h01;
      end else if (do_pop && !empty) begin
        sp_reg <= sp_reg - 5'h01;
      end else if (sw_sp) begin
        sp_reg <= pwdata[4:0];
      end
      // Hardware set wins over a clearing write in the same cycle
      full_reg  <= flag_full_set | (full_reg & ~(sw_sp & ~pwdata[FULL_BIT]));
      under_reg <= flag_under_set | (under_reg & ~(sw_sp & ~pwdata[UNDER_BIT]));
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi <= SP_MAX; gi++) begin : g_stack
      wire push_here = do_push && !is_full && (sp_reg + 5'h01 == 5'(gi));
      wire sw_here   = (sp_reg == 5'(gi)) && wr && (hit_tu | hit_th | hit_tl);
      always_ff @(posedge mclk) begin
        if (rst) begin
          stack_reg[gi] <= PC_RESET;
        end else if (push_here) begin
          // Overflow with reset enabled saves PC+2
          stack_reg[gi] <= trip ? pc_reg + PC_STEP : pc_reg;
        end else if (sw_here) begin
          stack_reg[gi] <= hit_tu ? {pwdata[4:0], stack_reg[gi][15:0]} :
                           hit_th ? {stack_reg[gi][20:16], pwdata[7:0], stack_reg[gi][7:0]} :
                                    {stack_reg[gi][20:8], pwdata[7:0]};
        end
      end
    end
  endgenerate

  // Program counter and instruction register
  wire pc_load = ph4 & (core_req.branch | do_pop) & ~flush_reg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_reg     <= PC_RESET;
      ir_reg     <= 16'h0000;
      flush_reg  <= 1'b0;
      ivalid_reg <= 1'b0;
    end else begin
      if (ph1) begin
        pc_reg <= pc_reg + PC_STEP;
      end else if (pc_load) begin
        // Underflow pop returns zero, which vectors to reset address
        pc_reg <= do_pop ? top_of_stack : pc_reg;
      end
      if (ph4) begin
        ir_reg     <= fetch_word;
        ivalid_reg <= ~pc_load;
        flush_reg  <= pc_load;
      end else if (ph1) begin
        flush_reg <= flush_reg;
      end
    end
  end

  // Fast register stack: hidden shadow
  always_ff @(posedge mclk) begin
    if (rst) begin
      shadow_reg    <= '0;
      restore_reg   <= '0;
      restore_v_reg <= 1'b0;
    end else begin
      restore_v_reg <= 1'b0;
      if (ph4 && (core_req.vector_irq || core_req.call_fast)) begin
        // Any vector overwrites; nested low-priority context is lost
        shadow_reg <= core_ctx;
      end
      if (ph4 && core_req.ret_fast) begin
        restore_reg   <= shadow_reg;
        restore_v_reg <= 1'b1;
      end
    end
  end

  // Table pointer and latch, one byte per read
  always_ff @(posedge mclk) begin
    if (rst) begin
      table_pointer_reg <= PC_RESET;
      table_latch_reg <= 8'h00;
    end else begin
      if (wr && hit_tp) begin
        table_pointer_reg <= pwdata[20:0];
      end
      if (table_read) begin
        table_latch_reg <= table_byte;
      end
    end
  end

  // Configuration and device reset pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_reg    <= CFG_RESET;
      devrst_reg <= 1'b0;
    end else begin
      if (wr && hit_cfg) begin
        cfg_reg <= pwdata[0];
      end
      devrst_reg <= trip;
    end
  end

  wire [31:0] rd_mux =
    hit_sp  ? {24'h00_0000, full_reg, under_reg, 1'b0, sp_reg} :
    hit_tu  ? {27'h000_0000, top_of_stack[20:16]} :
    hit_th  ? {24'h00_0000, top_of_stack[15:8]} :
    hit_tl  ? {24'h00_0000, top_of_stack[7:0]} :
    hit_cfg ? {31'h0000_0000, cfg_reg} :
    hit_st  ? {11'h000, pc_reg} :
    hit_sh  ? 32'h0000_0000 :
    hit_tp  ? {11'h000, table_pointer_reg} :
    hit_tlt ? {24'h00_0000, table_latch_reg} : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= (psel && !penable && !pwrite) ? rd_mux : prdata_reg;
      pslverr_reg <= psel & ~penable & ~mapped;
    end
  end

  assign pready            = 1'b1;
  // Set in the setup cycle, so it stands exactly for the access cycle
  assign pslverr           = pslverr_reg;
  assign prdata            = prdata_reg;
  assign pc_out            = pc_reg;
  assign instr_out         = ir_reg;
  assign instr_valid       = ivalid_reg;
  assign phase_out         = phase;
  assign ctx_restore       = restore_reg;
  assign ctx_restore_valid = restore_v_reg;
  assign table_addr        = table_pointer_reg;
  assign device_reset      = devrst_reg;

endmodule // rsp_core

// file: verilog/rsp_phase_gen.sv
`timescale 1ns/1ps
module rsp_phase_gen
  import rsp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  output logic [3:0]      phase_onehot
);

  // Divide by four: one-hot non-overlapping phases
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_onehot <= 4'h1;
    end else begin
      phase_onehot <= {phase_onehot[2:0], phase_onehot[3]};
    end
  end

endmodule // rsp_phase_gen

// file: verilog/rsp_pkg.sv
package rsp_pkg;

  localparam int PC_W    = 21;
  localparam int SP_W    = 5;
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 12;

  // Register byte addresses
  localparam logic [11:0] ADDR_RETURN_STACK_POINTER_REG = 12'h000;
  localparam logic [11:0] ADDR_TOP_OF_STACK_UPPER       = 12'h004;
  localparam logic [11:0] ADDR_TOP_OF_STACK_HIGH       = 12'h008;
  localparam logic [11:0] ADDR_TOP_OF_STACK_LOW       = 12'h00C;
  localparam logic [11:0] ADDR_CONFIG     = 12'h010;
  localparam logic [11:0] ADDR_STATUS     = 12'h014;
  localparam logic [11:0] ADDR_SHADOW     = 12'h018;
  localparam logic [11:0] ADDR_TABLE_PTR  = 12'h01C;
  localparam logic [11:0] ADDR_TABLE_LAT  = 12'h020;

  // Pointer register fields
  localparam int FULL_BIT  = 7;
  localparam int UNDER_BIT = 6;

  localparam logic [4:0]  SP_MAX       = 5'h1F;
  localparam logic [4:0]  SP_RESET     = 5'h00;
  localparam logic [20:0] PC_RESET     = 21'h00_0000;
  localparam logic [20:0] PC_STEP      = 21'h00_0002;
  localparam logic        CFG_RESET    = 1'b1;
  localparam logic [1:0]  PHASE_LAST   = 2'h3;

  typedef enum logic [1:0] {
    RSP_PH_ONE,
    RSP_PH_TWO,
    RSP_PH_THREE,
    RSP_PH_FOUR
  } rsp_phase_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working;
    logic [3:0] bank;
  } rsp_ctx_t;

  // Core requests, sampled at the phase-four boundary
  typedef struct packed {
    logic push;
    logic pop;
    logic branch;
    logic vector_irq;
    logic call_fast;
    logic ret_fast;
  } rsp_req_t;

endpackage
